// ===== inc/pmac_pkg.sv
/*
 * constants and types shared by the power-mode / antenna control block.
 * assumes one 10 MHz clock and a synchronous active-low reset.
 */
package pmac_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned SYNC_STAGES     = 3;
    // clean strap level is first valid after SYNC_STAGES + 1 edges;
    // capture one edge later so the reset value of the filter is not taken
    localparam int unsigned STRAP_SETTLE_CYC = SYNC_STAGES + 2;
    localparam int unsigned SETTLE_W        = 3;

    // ==========================================================
    // synchronised pin vector layout
    localparam int unsigned SI_STRAP = 0;
    localparam int unsigned SI_EXT0  = 1;
    localparam int unsigned SI_EXT1  = 2;
    localparam int unsigned SI_SHORT = 3;
    localparam int unsigned SI_RX    = 4;
    localparam int unsigned SI_DAT   = 5;
    localparam int unsigned SI_CLK   = 6;
    localparam int unsigned SI_N     = 7;
    // idle levels: strap open reads high, serial and two-wire idle high
    localparam logic [SI_N-1:0] SI_RST = 7'h71;

    // ==========================================================
    // operating modes and controller states
    localparam logic MODE_CONT  = 1'b0;
    localparam logic MODE_ONOFF = 1'b1;

    typedef enum logic [1:0] {
        ST_CONT_ACQ,
        ST_CONT_TRACK,
        ST_CYC_ON,
        ST_CYC_IDLE
    } pmac_state_e;

    localparam int unsigned PERIOD_W = 32;

endpackage : pmac_pkg

// ===== inc/pmac_sync_if.sv
/*
 * raw pin levels in, filtered levels out, between the control core
 * and its pin synchroniser. assumes both ends share one clock.
 */
interface pmac_sync_if #(
    parameter int unsigned W = 7
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface : pmac_sync_if

// ===== core/pmac_pin_sync.sv
/*
 * three-stage synchroniser per pin; the clean level changes only when
 * the second and third stages agree. assumes raw levels are
 * asynchronous to clk.
 */
module pmac_pin_sync #(
    parameter int unsigned     W       = 7,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // clock and reset
    input wire logic   clk,
    input wire logic   rst_b,
    // pin levels
    pmac_sync_if.filt  sif
);

    // ==========================================================
    // per-bit stages
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1_ff, s2_ff, s3_ff, clean_ff;
        logic nxt_s1, nxt_s2, nxt_s3, nxt_clean;

        always_comb begin
            nxt_s1    = sif.raw[i];
            nxt_s2    = s1_ff;
            nxt_s3    = s2_ff;
            // s1 feeds only s2; the vote looks at s2 and s3
            nxt_clean = (s2_ff == s3_ff) ? s3_ff : clean_ff;
        end

        always_ff @(posedge clk) begin
            if (!rst_b) begin
                s1_ff    <= RST_VAL[i];
                s2_ff    <= RST_VAL[i];
                s3_ff    <= RST_VAL[i];
                clean_ff <= RST_VAL[i];
            end else begin
                s1_ff    <= nxt_s1;
                s2_ff    <= nxt_s2;
                s3_ff    <= nxt_s3;
                clean_ff <= nxt_clean;
            end
        end

        assign sif.clean[i] = clean_ff;
    end

endmodule : pmac_pin_sync

// ===== core/pmac_ctrl.sv
/*
 * power-mode sequencer, antenna supply control and shared host pin
 * routing of a satellite timing receiver.
 * assumes one clock, the engine status inputs on that clock, and all
 * pin inputs asynchronous.
 */
// Operation
// - strap high or open gives two-wire data/clock, low gives spi cs/clock.
// - strap high or open gives serial tx/rx, low gives spi miso/mosi.
// - only two modes exist: continuous and on/off duty cycle.
// - continuous mode acquires until the almanac is complete, then tracks.
// - low tracking current needs position, full almanac and all ephemeris.
// - duty mode wakes on timer, event input 0, event input 1 while open detection is off, or serial rx activity.
// - when enabled, the event input 0 level holds the receiver on or off.
// - after each wake the receiver stays on until a new fix is delivered.
// - antenna bias is on while active, off while idle and while shorted.
// - a near-zero antenna supply flags a short alarm.
// - event input 1 may serve as an open-circuit indication in status.
// - the antenna switch output follows the same policy as the bias.
module pmac_ctrl #(
    parameter int unsigned PERIOD_W = pmac_pkg::PERIOD_W
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // strap, event and antenna sense pins
    input  wire logic                iface_select_strap,
    input  wire logic                external_event_input_0,
    input  wire logic                external_event_input_1,
    input  wire logic                ant_supply_near_zero,
    // shared host pins
    input  wire logic                dat_pin_in,
    output logic                     dat_pin_out,
    output logic                     dat_pin_oe_b,
    input  wire logic                clk_pin_in,
    output logic                     clk_pin_out,
    output logic                     clk_pin_oe_b,
    output logic                     tx_pin_out,
    input  wire logic                rx_pin_in,
    // two-wire core side
    input  wire logic                twi_dat_pull,
    input  wire logic                twi_clk_pull,
    output logic                     twi_dat_in,
    output logic                     twi_clk_in,
    // serial port core side
    input  wire logic                uart_txd,
    output logic                     uart_rxd,
    // spi core side
    input  wire logic                spi_miso,
    output logic                     spi_cs_b,
    output logic                     spi_sck,
    output logic                     spi_mosi,
    // configuration
    input  wire logic                cfg_mode,
    input  wire logic [PERIOD_W-1:0] cfg_wake_period,
    input  wire logic                cfg_hold_en,
    input  wire logic                cfg_open_det_en,
    input  wire logic                cfg_ant_ctrl_en,
    // engine status
    input  wire logic                pos_valid,
    input  wire logic                almanac_done,
    input  wire logic                eph_all_valid,
    input  wire logic                new_fix,
    // status and control outputs
    output logic                     iface_is_spi,
    output logic                     rx_active,
    output logic                     acq_full,
    output logic                     track_low,
    output logic                     ant_bias_en,
    output logic                     antenna_supply_switch_out,
    output logic                     alarm_short,
    output logic                     alarm_open
);
    // ==========================================================
    // pin synchroniser
    pmac_sync_if #(.W(pmac_pkg::SI_N)) sif ();
    assign sif.raw = {clk_pin_in, dat_pin_in, rx_pin_in,
                      ant_supply_near_zero, external_event_input_1,
                      external_event_input_0, iface_select_strap};
    pmac_pin_sync #(
        .W       (pmac_pkg::SI_N),
        .RST_VAL (pmac_pkg::SI_RST)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .sif   (sif)
    );
    logic strap_c, ext0_c, ext1_c, short_c, rx_c, dat_c, clk_c;
    assign strap_c = sif.clean[pmac_pkg::SI_STRAP];
    assign ext0_c  = sif.clean[pmac_pkg::SI_EXT0];
    assign ext1_c  = sif.clean[pmac_pkg::SI_EXT1];
    assign short_c = sif.clean[pmac_pkg::SI_SHORT];
    assign rx_c    = sif.clean[pmac_pkg::SI_RX];
    assign dat_c   = sif.clean[pmac_pkg::SI_DAT];
    assign clk_c   = sif.clean[pmac_pkg::SI_CLK];
    // ==========================================================
    // strap capture
    logic [pmac_pkg::SETTLE_W-1:0] settle_ff, nxt_settle;
    logic                          spi_ff, nxt_spi;
    always_comb begin
        nxt_settle = settle_ff;
        nxt_spi    = spi_ff;
        if (settle_ff != pmac_pkg::SETTLE_W'(pmac_pkg::STRAP_SETTLE_CYC))
        begin
            nxt_settle = settle_ff + 1'b1;
            // single capture, held until the next reset
            if (settle_ff ==
                pmac_pkg::SETTLE_W'(pmac_pkg::STRAP_SETTLE_CYC - 1)) begin
                nxt_spi = !strap_c;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            settle_ff <= '0;
            spi_ff    <= 1'b0;
        end else begin
            settle_ff <= nxt_settle;
            spi_ff    <= nxt_spi;
        end
    end

    // ==========================================================
    // pin routing
    logic dat_out_ff, dat_oe_b_ff, clk_out_ff, clk_oe_b_ff, tx_ff;
    logic twi_dat_ff, twi_clk_ff, rxd_ff, cs_b_ff, sck_ff, mosi_ff;
    logic nxt_dat_out, nxt_dat_oe_b, nxt_clk_out, nxt_clk_oe_b, nxt_tx;
    logic nxt_twi_dat, nxt_twi_clk, nxt_rxd, nxt_cs_b, nxt_sck, nxt_mosi;
    always_comb begin
        // open-drain: only ever drive low, pins are inputs in spi mode
        nxt_dat_out  = 1'b0;
        nxt_clk_out  = 1'b0;
        nxt_dat_oe_b = spi_ff ? 1'b1 : !twi_dat_pull;
        nxt_clk_oe_b = spi_ff ? 1'b1 : !twi_clk_pull;
        nxt_twi_dat  = spi_ff ? 1'b1 : dat_c;
        nxt_twi_clk  = spi_ff ? 1'b1 : clk_c;
        nxt_cs_b     = spi_ff ? dat_c : 1'b1;
        nxt_sck      = spi_ff ? clk_c : 1'b0;
        nxt_tx       = spi_ff ? spi_miso : uart_txd;
        nxt_rxd      = spi_ff ? 1'b1 : rx_c;
        nxt_mosi     = spi_ff ? rx_c : 1'b0;
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dat_out_ff  <= 1'b0;
            dat_oe_b_ff <= 1'b1;
            clk_out_ff  <= 1'b0;
            clk_oe_b_ff <= 1'b1;
            tx_ff       <= 1'b1;
            twi_dat_ff  <= 1'b1;
            twi_clk_ff  <= 1'b1;
            rxd_ff      <= 1'b1;
            cs_b_ff     <= 1'b1;
            sck_ff      <= 1'b0;
            mosi_ff     <= 1'b0;
        end else begin
            dat_out_ff  <= nxt_dat_out;
            dat_oe_b_ff <= nxt_dat_oe_b;
            clk_out_ff  <= nxt_clk_out;
            clk_oe_b_ff <= nxt_clk_oe_b;
            tx_ff       <= nxt_tx;
            twi_dat_ff  <= nxt_twi_dat;
            twi_clk_ff  <= nxt_twi_clk;
            rxd_ff      <= nxt_rxd;
            cs_b_ff     <= nxt_cs_b;
            sck_ff      <= nxt_sck;
            mosi_ff     <= nxt_mosi;
        end
    end

    // ==========================================================
    // power-mode sequencer
    pmac_pkg::pmac_state_e state_ff, nxt_state;
    logic [PERIOD_W-1:0]   timer_ff, nxt_timer;
    logic                  ext0_d_ff, ext1_d_ff, rx_d_ff;
    logic                  wake, hold_req;
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        hold_req  = cfg_hold_en && ext0_c;
        // wake sources; event 1 is lost to open detection when reassigned
        wake = (timer_ff == '0)
            || (ext0_c && !ext0_d_ff)
            || (!cfg_open_det_en && ext1_c && !ext1_d_ff)
            || (!spi_ff && !rx_c && rx_d_ff);
        if (timer_ff != '0) begin
            nxt_timer = timer_ff - 1'b1;
        end
        unique case (state_ff)
            pmac_pkg::ST_CONT_ACQ: begin
                if (cfg_mode == pmac_pkg::MODE_ONOFF) begin
                    nxt_state = pmac_pkg::ST_CYC_ON;
                end else if (almanac_done) begin
                    nxt_state = pmac_pkg::ST_CONT_TRACK;
                end
            end
            pmac_pkg::ST_CONT_TRACK: begin
                if (cfg_mode == pmac_pkg::MODE_ONOFF) begin
                    nxt_state = pmac_pkg::ST_CYC_ON;
                end else if (!almanac_done) begin
                    nxt_state = pmac_pkg::ST_CONT_ACQ;
                end
            end
            pmac_pkg::ST_CYC_ON: begin
                if (cfg_mode == pmac_pkg::MODE_CONT) begin
                    nxt_state = pmac_pkg::ST_CONT_ACQ;
                end else if (cfg_hold_en ? !hold_req : new_fix) begin
                    nxt_state = pmac_pkg::ST_CYC_IDLE;
                    nxt_timer = cfg_wake_period;
                end
            end
            pmac_pkg::ST_CYC_IDLE: begin
                if (cfg_mode == pmac_pkg::MODE_CONT) begin
                    nxt_state = pmac_pkg::ST_CONT_ACQ;
                end else if (cfg_hold_en ? hold_req : wake) begin
                    nxt_state = pmac_pkg::ST_CYC_ON;
                end
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff  <= pmac_pkg::ST_CONT_ACQ;
            timer_ff  <= '0;
            ext0_d_ff <= 1'b0;
            ext1_d_ff <= 1'b0;
            rx_d_ff   <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            timer_ff  <= nxt_timer;
            ext0_d_ff <= ext0_c;
            ext1_d_ff <= ext1_c;
            rx_d_ff   <= rx_c;
        end
    end

    // ==========================================================
    // status and antenna supply
    logic act_ff, acq_ff, trk_ff, bias_ff, sw_ff, ashort_ff, aopen_ff;
    logic nxt_act, nxt_acq, nxt_trk, nxt_bias, nxt_ashort, nxt_aopen;
    always_comb begin
        // reflects the state being entered, so the bias tracks the sequencer
        nxt_act    = (nxt_state != pmac_pkg::ST_CYC_IDLE);
        nxt_acq    = (nxt_state == pmac_pkg::ST_CONT_ACQ)
                  || (nxt_state == pmac_pkg::ST_CYC_ON);
        nxt_trk    = (nxt_state == pmac_pkg::ST_CONT_TRACK)
                  && pos_valid && almanac_done && eph_all_valid;
        nxt_ashort = short_c;
        nxt_aopen  = cfg_open_det_en && ext1_c;
        // short wins over activity; control disabled leaves supply on
        nxt_bias   = cfg_ant_ctrl_en ? (nxt_act && !short_c) : 1'b1;
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            act_ff    <= 1'b0;
            acq_ff    <= 1'b0;
            trk_ff    <= 1'b0;
            bias_ff   <= 1'b0;
            sw_ff     <= 1'b0;
            ashort_ff <= 1'b0;
            aopen_ff  <= 1'b0;
        end else begin
            act_ff    <= nxt_act;
            acq_ff    <= nxt_acq;
            trk_ff    <= nxt_trk;
            bias_ff   <= nxt_bias;
            sw_ff     <= nxt_bias;
            ashort_ff <= nxt_ashort;
            aopen_ff  <= nxt_aopen;
        end
    end

    // ==========================================================
    // outputs
    assign dat_pin_out               = dat_out_ff;
    assign dat_pin_oe_b              = dat_oe_b_ff;
    assign clk_pin_out               = clk_out_ff;
    assign clk_pin_oe_b              = clk_oe_b_ff;
    assign tx_pin_out                = tx_ff;
    assign twi_dat_in                = twi_dat_ff;
    assign twi_clk_in                = twi_clk_ff;
    assign uart_rxd                  = rxd_ff;
    assign spi_cs_b                  = cs_b_ff;
    assign spi_sck                   = sck_ff;
    assign spi_mosi                  = mosi_ff;
    assign iface_is_spi              = spi_ff;
    assign rx_active                 = act_ff;
    assign acq_full                  = acq_ff;
    assign track_low                 = trk_ff;
    assign ant_bias_en               = bias_ff;
    assign antenna_supply_switch_out = sw_ff;
    assign alarm_short               = ashort_ff;
    assign alarm_open                = aopen_ff;

endmodule : pmac_ctrl

// ===== test/pmac_host_model.sv
/*
 * host side of the receiver pins: strap, event lines, antenna sense,
 * serial receive and the two open-drain shared pins with pull-ups.
 * assumes the bench calls pin() just after a falling clock edge.
 */
module pmac_host_model (
    // levels towards the receiver
    output wire logic strap, ev0, ev1, near0, rx,
    output wire logic dat_w, clk_w,
    // receiver drive of the open-drain pins
    input  wire logic dat_oe_b, clk_oe_b, dat_out, clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // pin state
    // strap open and idle lines read high
    logic [6:0] p = 7'h71;
    assign {rx, near0, ev1, ev0, strap} = p[4:0];
    // released pins fall back to the pull-up, never the last level
    assign dat_w = p[5] & (dat_oe_b | dat_out);
    assign clk_w = p[6] & (clk_oe_b | clk_out);
    task automatic pin(input int k, input logic v);
        p[k] = v;
    endtask : pin
endmodule : pmac_host_model

// ===== test/pmac_ctrl_checker.sv
/*
 * concurrent checks on the ports of pmac_ctrl.
 * assumes one clock domain and the synchronous active-low reset.
 */
module pmac_ctrl_checker #(
    parameter int unsigned PERIOD_W = 32
) (
    // clock and reset
    input wire logic clk, rst_b,
    // routing
    input wire logic iface_is_spi, spi_cs_b, spi_sck, spi_mosi, uart_rxd,
    input wire logic tx_pin_out, spi_miso, uart_txd, dat_pin_oe_b,
    input wire logic twi_dat_pull,
    // configuration and engine status
    input wire logic cfg_mode, cfg_hold_en, cfg_open_det_en, cfg_ant_ctrl_en,
    input wire logic [PERIOD_W-1:0] cfg_wake_period,
    input wire logic pos_valid, almanac_done, eph_all_valid, new_fix,
    // status
    input wire logic rx_active, acq_full, track_low, ant_bias_en,
    input wire logic antenna_supply_switch_out, alarm_short, alarm_open
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // edges since reset release; routing is settled at the top value
    logic [3:0] rel_ff, nxt_rel;
    always_comb
        nxt_rel = !rst_b ? 4'h0 : (rel_ff == 4'hf) ? rel_ff : rel_ff + 4'h1;
    always_ff @(posedge clk) rel_ff <= nxt_rel;
    sequence s_on_fix;
        $past(cfg_mode) && cfg_mode && !cfg_hold_en && rx_active && new_fix;
    endsequence
    sequence s_idle;
        !rx_active && !acq_full;
    endsequence
    sequence s_sleep;
        $fell(rx_active) && cfg_mode && !cfg_hold_en && cfg_wake_period < 32'h20;
    endsequence
    property p_sw_same;
        antenna_supply_switch_out == ant_bias_en;
    endproperty
    a_sw_same: assert property (p_sw_same) else $error("switch out differs");
    property p_bias;
        $past(rst_b) |-> ant_bias_en ==
            ($past(cfg_ant_ctrl_en) ? (rx_active && !alarm_short) : 1'b1);
    endproperty
    a_bias: assert property (p_bias) else $error("antenna bias wrong");
    property p_side_idle;
        rel_ff == 4'hf |-> (iface_is_spi ? uart_rxd
                                          : (spi_cs_b && !spi_sck && !spi_mosi));
    endproperty
    a_side_idle: assert property (p_side_idle) else $error("unused side active");
    property p_tx;
        rel_ff == 4'hf |->
            tx_pin_out == (iface_is_spi ? $past(spi_miso) : $past(uart_txd));
    endproperty
    a_tx: assert property (p_tx) else $error("tx pin source wrong");
    property p_oe;
        rel_ff == 4'hf && !iface_is_spi |-> dat_pin_oe_b == !$past(twi_dat_pull);
    endproperty
    a_oe: assert property (p_oe) else $error("data pin drive wrong");
    property p_strap;
        rel_ff == 4'hf |-> $stable(iface_is_spi);
    endproperty
    a_strap: assert property (p_strap) else $error("routing moved");
    property p_open;
        $past(rst_b) && !$past(cfg_open_det_en) |-> !alarm_open;
    endproperty
    a_open: assert property (p_open) else $error("open alarm not enabled");
    property p_track;
        track_low |-> !$past(cfg_mode) && !acq_full &&
            $past(pos_valid && almanac_done && eph_all_valid);
    endproperty
    a_track: assert property (p_track) else $error("low tracking too early");
    property p_fix;
        s_on_fix |=> s_idle;
    endproperty
    a_fix: assert property (p_fix) else $error("no idle after fix");
    property p_wake;
        s_sleep |-> ##[1:40] rx_active;
    endproperty
    a_wake: assert property (p_wake) else $error("timer wake missing");
endmodule : pmac_ctrl_checker

bind pmac_ctrl pmac_ctrl_checker #(.PERIOD_W(PERIOD_W)) u_chk (.*);

// ===== test/tb_top.sv
/*
 * self-checking bench of pmac_ctrl with the host pin model.
 * assumes pmac_ctrl, its package and the checker are compiled first.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // signals
    logic clk, rst_b, twi_dat_pull, twi_clk_pull, uart_txd, spi_miso;
    logic cfg_mode, cfg_hold_en, cfg_open_det_en, cfg_ant_ctrl_en;
    logic [31:0] cfg_wake_period;
    logic pos_valid, almanac_done, eph_all_valid, new_fix;
    wire logic iface_select_strap, external_event_input_0;
    wire logic external_event_input_1, ant_supply_near_zero;
    wire logic dat_pin_in, clk_pin_in, rx_pin_in, dat_pin_out, dat_pin_oe_b;
    wire logic clk_pin_out, clk_pin_oe_b, tx_pin_out, twi_dat_in, twi_clk_in;
    wire logic uart_rxd, spi_cs_b, spi_sck, spi_mosi, iface_is_spi, rx_active;
    wire logic acq_full, track_low, ant_bias_en, antenna_supply_switch_out;
    wire logic alarm_short, alarm_open;
    int miscompares = 0;
    int cmp_count = 0;
    localparam int STRAP = 0, EV0 = 1, EV1 = 2, NEAR0 = 3, RX = 4, DAT = 5;
    pmac_ctrl dut (.*);
    pmac_host_model host (.strap(iface_select_strap),
        .ev0(external_event_input_0), .ev1(external_event_input_1),
        .near0(ant_supply_near_zero), .rx(rx_pin_in), .dat_w(dat_pin_in),
        .clk_w(clk_pin_in), .dat_oe_b(dat_pin_oe_b), .clk_oe_b(clk_pin_oe_b),
        .dat_out(dat_pin_out), .clk_out(clk_pin_out));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========================================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    // bounded wait; running out ends the run
    task automatic wait_rx(input logic lvl, input int bound);
        int i;
        for (i = 0; i < bound && rx_active !== lvl; i++) cyc(1);
        chk("rx_active", lvl, rx_active);
        if (rx_active !== lvl) final_report();
    endtask : wait_rx
    task automatic do_reset(input logic strap);
        host.pin(STRAP, strap);
        rst_b = 1'b0;
        cyc(16);
        rst_b = 1'b1;
        cyc(7);
        chk("iface_is_spi", !strap, iface_is_spi);
    endtask : do_reset
    task automatic fix_pulse();
        new_fix = 1'b1;
        cyc(1);
        new_fix = 1'b0;
    endtask : fix_pulse
    // ==========================================================
    // scenarios
    task automatic t_twi();
        do_reset(1'b1);
        host.pin(DAT, 1'b0);
        host.pin(RX, 1'b0);
        twi_clk_pull = 1'b1;
        twi_dat_pull = 1'b1;
        uart_txd = 1'b0;
        cyc(6);
        chk("twi_dat_in", 1'b0, twi_dat_in);
        chk("clk_pin_oe_b", 1'b0, clk_pin_oe_b);
        chk("dat_pin_oe_b", 1'b0, dat_pin_oe_b);
        chk("dat_pin_out", 1'b0, dat_pin_out);
        chk("clk_pin_out", 1'b0, clk_pin_out);
        chk("twi_clk_in", 1'b0, twi_clk_in);
        chk("spi_cs_b", 1'b1, spi_cs_b);
        chk("tx_pin_out", 1'b0, tx_pin_out);
        chk("uart_rxd", 1'b0, uart_rxd);
        host.pin(STRAP, 1'b0);
        cyc(10);
        chk("iface_is_spi", 1'b0, iface_is_spi);
        chk("twi_dat_in", 1'b0, twi_dat_in);
        twi_clk_pull = 1'b0;
        twi_dat_pull = 1'b0;
        uart_txd = 1'b1;
    endtask : t_twi
    task automatic t_spi();
        do_reset(1'b0);
        twi_dat_pull = 1'b1;
        cyc(6);
        chk("spi_cs_b", 1'b0, spi_cs_b);
        chk("spi_sck", 1'b1, spi_sck);
        chk("twi_dat_in", 1'b1, twi_dat_in);
        chk("dat_pin_oe_b", 1'b1, dat_pin_oe_b);
        chk("spi_mosi", 1'b0, spi_mosi);
        chk("tx_pin_out", 1'b0, tx_pin_out);
        chk("uart_rxd", 1'b1, uart_rxd);
        twi_dat_pull = 1'b0;
        host.pin(DAT, 1'b1);
        host.pin(RX, 1'b1);
        cyc(6);
        chk("spi_mosi", 1'b1, spi_mosi);
    endtask : t_spi
    task automatic t_cont();
        chk("acq_full", 1'b1, acq_full);
        almanac_done = 1'b1;
        cyc(2);
        chk("acq_full", 1'b0, acq_full);
        chk("track_low", 1'b0, track_low);
        pos_valid = 1'b1;
        eph_all_valid = 1'b1;
        cyc(2);
        chk("track_low", 1'b1, track_low);
        eph_all_valid = 1'b0;
        almanac_done = 1'b0;
        cyc(2);
        chk("track_low", 1'b0, track_low);
        chk("acq_full", 1'b1, acq_full);
    endtask : t_cont
    task automatic t_duty();
        int srcs[3] = '{EV0, EV1, RX};
        cfg_mode = 1'b1;
        cyc(2);
        chk("rx_active", 1'b1, rx_active);
        fix_pulse();
        chk("rx_active", 1'b0, rx_active);
        chk("acq_full", 1'b0, acq_full);
        chk("ant_bias_en", 1'b0, ant_bias_en);
        chk("antenna_supply_switch_out", 1'b0, antenna_supply_switch_out);
        cyc(6);
        chk("rx_active", 1'b0, rx_active);
        wait_rx(1'b1, 8);
        cfg_wake_period = 32'hffff;
        foreach (srcs[i]) begin
            fix_pulse();
            cyc(20);
            chk("rx_active", 1'b0, rx_active);
            host.pin(srcs[i], srcs[i] != RX);
            wait_rx(1'b1, 8);
            host.pin(srcs[i], srcs[i] == RX);
        end
    endtask : t_duty
    task automatic t_hold();
        cfg_hold_en = 1'b1;
        cfg_wake_period = 32'h0;
        wait_rx(1'b0, 8);
        cyc(20);
        chk("rx_active", 1'b0, rx_active);
        host.pin(EV0, 1'b1);
        wait_rx(1'b1, 8);
        fix_pulse();
        cyc(3);
        chk("rx_active", 1'b1, rx_active);
        host.pin(EV0, 1'b0);
        wait_rx(1'b0, 8);
        cfg_hold_en = 1'b0;
    endtask : t_hold
    task automatic t_ant();
        cfg_mode = 1'b0;
        cyc(3);
        chk("ant_bias_en", 1'b1, ant_bias_en);
        host.pin(NEAR0, 1'b1);
        cyc(6);
        chk("alarm_short", 1'b1, alarm_short);
        chk("ant_bias_en", 1'b0, ant_bias_en);
        chk("antenna_supply_switch_out", 1'b0, antenna_supply_switch_out);
        cfg_ant_ctrl_en = 1'b0;
        cyc(2);
        chk("ant_bias_en", 1'b1, ant_bias_en);
        host.pin(NEAR0, 1'b0);
        host.pin(EV1, 1'b1);
        cfg_open_det_en = 1'b1;
        cyc(6);
        chk("alarm_short", 1'b0, alarm_short);
        chk("alarm_open", 1'b1, alarm_open);
        cfg_open_det_en = 1'b0;
        cyc(2);
        chk("alarm_open", 1'b0, alarm_open);
    endtask : t_ant
    // ==========================================================
    // main sequence
    initial begin
        {rst_b, twi_dat_pull, twi_clk_pull, spi_miso, cfg_mode} = 5'h0;
        {cfg_hold_en, cfg_open_det_en, pos_valid, almanac_done} = 4'h0;
        {eph_all_valid, new_fix} = 2'h0;
        uart_txd = 1'b1;
        cfg_ant_ctrl_en = 1'b1;
        cfg_wake_period = 32'h8;
        t_twi();
        t_spi();
        do_reset(1'b1);
        t_cont();
        t_duty();
        t_hold();
        t_ant();
        final_report();
    end
endmodule : tb_top
